// ### core/tod_pkg.sv
// Package: constants, field layouts and types of the touch output and option decode block
//
// What this block does
// - Timing byte bit 2 picks 20 ms sample interval when clear, 10 ms when set.
// - Timing byte bit 1 picks 125 kHz transfer rate when clear, 250 kHz when set.
// - Behaviour bits 7:6: low power zoom, normal, extreme low zoom, extreme low.
// - Behaviour bits 5:4: standard/sensitive proximity and touch margin selection.
// - Behaviour bits 3:2: freeze limit 15 s, 45 s, reserved, or infinite.
// - Behaviour bits 1:0: follow, toggle, three-second latch, thirty-second latch.
// - Unprogrammed option bytes read all zero, giving the zero encoding of each field.
// - Actuation is a rising detection flag; asserted output is high, idle is low.
// - The detection output pin is active high.
// - Every rise of the output stays high for at least the minimum pulse time.
// - Follow mode: output high while detection persists, and for at least the minimum pulse time.
// - Toggle mode: each actuation inverts the output; detection end changes nothing.
// - Three-second latch: high at least 3 s, longer while detection lasts.
// - Thirty-second latch: falls 30 s after detection ended.
// - Thirty-second latch: new actuation restarts the 30 s hold.
// - Margins rank sensitive proximity, standard proximity, sensitive touch, standard touch.
// - Detection when signal falls below reference minus selected margin.
// - Flag sets after entry debounce run, clears after exit debounce run.
// - Reference frozen during detection; tracking resumes after freeze limit expires.
// - Low power zoom untouched: acquire every fifth interval; every interval when active.
package tod_pkg;

   // ==========================================
   // Clock and timing
   localparam int CLK_HZ = 25_000_000;
   localparam int BASE_MS = 10;
   localparam int BASE_CYC = CLK_HZ / 1000 * BASE_MS;
   localparam int SAMPLE_FAST_MS = 10;
   localparam int SAMPLE_SLOW_MS = 20;
   localparam int XFER_SLOW_HZ = 125_000;
   localparam int XFER_FAST_HZ = 250_000;
   localparam logic [7:0] XFER_SLOW_CYC = 8'(CLK_HZ / XFER_SLOW_HZ);
   localparam logic [7:0] XFER_FAST_CYC = 8'(CLK_HZ / XFER_FAST_HZ);
   localparam int LATCH3_MS = 3000;
   localparam int LATCH30_MS = 30000;
   localparam int FREEZE15_MS = 15000;
   localparam int FREEZE45_MS = 45000;
   localparam int MIN_PULSE_MS = 60;
   localparam logic [4:0] ACQ_NORMAL = 5'h01;
   localparam logic [4:0] ACQ_LOW = 5'h05;
   localparam logic [4:0] ACQ_EXTREME = 5'h11;
   localparam logic [1:0] CAPTURE_DELAY = 2'h2;

   // ==========================================
   // Register map
   localparam logic [7:0] ADDR_TIMING = 8'h00;
   localparam logic [7:0] ADDR_BEHAV = 8'h04;
   localparam logic [7:0] ADDR_DEBOUNCE = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_REFERENCE = 8'h10;
   localparam logic [7:0] OPT_TIMING_RST = 8'h00;
   localparam logic [7:0] OPT_BEHAV_RST = 8'h00;
   localparam logic [3:0] ENTRY_DEB_RST = 4'h3;
   localparam logic [3:0] EXIT_DEB_RST = 4'h3;
   localparam int DEB_ENTRY_LSB = 0;
   localparam int DEB_EXIT_LSB = 4;

   // ==========================================
   // Option fields
   typedef enum logic [1:0] {PM_LOW_ZOOM, PM_NORMAL, PM_EXTREME_ZOOM, PM_EXTREME} tod_power_t;
   typedef enum logic [1:0] {MG_STD_PROX, MG_STD_TOUCH, MG_SENS_PROX, MG_SENS_TOUCH} tod_margin_t;
   typedef enum logic [1:0] {FRZ_15S, FRZ_45S, FRZ_RSVD, FRZ_INFINITE} tod_freeze_t;
   typedef enum logic [1:0] {OM_FOLLOW, OM_TOGGLE, OM_LATCH3, OM_LATCH30} tod_outmode_t;

   typedef struct packed {
      tod_power_t power;
      tod_margin_t margin;
      tod_freeze_t freeze;
      tod_outmode_t outmode;
   } tod_behav_t;

   typedef struct packed {
      logic [4:0] rsvd_hi;
      logic fast_sample;
      logic fast_xfer;
      logic rsvd_lo;
   } tod_timing_t;

   typedef struct packed {
      logic valid;
      logic [15:0] count;
   } tod_meas_t;

endpackage : tod_pkg

// ### core/tod_sensor_out.sv
// Module: option byte decode, detection filter and detection output pin driver
`timescale 1ns/1ps

module tod_sensor_out #(
   parameter int BASE_CYC = tod_pkg::BASE_CYC,
   parameter logic [15:0] MARGIN_SENS_PROX = 16'h0004,
   parameter logic [15:0] MARGIN_STD_PROX = 16'h0008,
   parameter logic [15:0] MARGIN_SENS_TOUCH = 16'h0010,
   parameter logic [15:0] MARGIN_STD_TOUCH = 16'h0020
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] timing_option_byte,
   input wire logic [7:0] behaviour_option_byte,
   input wire tod_pkg::tod_meas_t meas,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic detect_output_pin,
   output logic transfer_tick,
   output logic acq_request
);
   import tod_pkg::*;

   localparam int BW = $clog2(BASE_CYC + 1);

   // ==========================================
   // Helper functions
   function automatic logic [12:0] ms_to_samples(input int ms, input logic fast);
      int n;
      n = fast ? ms / SAMPLE_FAST_MS : ms / SAMPLE_SLOW_MS;
      if (n < 1) begin
         n = 1;
      end
      return 13'(n);
   endfunction : ms_to_samples

   function automatic logic [15:0] margin_of(input tod_margin_t sel);
      logic [15:0] m;
      m = MARGIN_STD_PROX;
      case (sel)
         MG_STD_PROX: m = MARGIN_STD_PROX;
         MG_STD_TOUCH: m = MARGIN_STD_TOUCH;
         MG_SENS_PROX: m = MARGIN_SENS_PROX;
         MG_SENS_TOUCH: m = MARGIN_SENS_TOUCH;
         default: m = MARGIN_STD_PROX;
      endcase
      return m;
   endfunction : margin_of

   function automatic logic [4:0] acq_interval(input tod_power_t pm, input logic awake);
      logic [4:0] n;
      n = ACQ_NORMAL;
      case (pm)
         PM_NORMAL: n = ACQ_NORMAL;
         PM_LOW_ZOOM: n = awake ? ACQ_NORMAL : ACQ_LOW;
         PM_EXTREME_ZOOM: n = awake ? ACQ_NORMAL : ACQ_EXTREME;
         PM_EXTREME: n = ACQ_EXTREME;
         default: n = ACQ_NORMAL;
      endcase
      return n;
   endfunction : acq_interval

   // ==========================================
   // Option byte capture
   logic [15:0] opt_sync1_q;
   logic [15:0] opt_sync2_q;
   logic [1:0] cap_cnt_q;
   logic cap_done_q;
   tod_timing_t opt_t_q;
   tod_behav_t opt_b_q;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         opt_sync1_q <= 16'h0000;
         opt_sync2_q <= 16'h0000;
      end else begin
         opt_sync1_q <= {timing_option_byte, behaviour_option_byte};
         opt_sync2_q <= opt_sync1_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cap_cnt_q <= 2'h0;
         cap_done_q <= 1'b0;
         opt_t_q <= tod_timing_t'(OPT_TIMING_RST);
         opt_b_q <= tod_behav_t'(OPT_BEHAV_RST);
      end else if (!cap_done_q) begin
         if (cap_cnt_q == CAPTURE_DELAY) begin
            opt_t_q <= tod_timing_t'(opt_sync2_q[15:8]);
            opt_b_q <= tod_behav_t'(opt_sync2_q[7:0]);
            cap_done_q <= 1'b1;
         end else begin
            cap_cnt_q <= cap_cnt_q + 2'h1;
         end
      end
   end

   // ==========================================
   // Decoded settings
   logic fast;
   logic [7:0] xfer_lim;
   logic [12:0] latch3_n;
   logic [12:0] latch30_n;
   logic [12:0] min_pulse_n;
   logic [12:0] freeze_n;
   logic [15:0] margin;

   always_comb begin
      fast = opt_t_q.fast_sample;
      xfer_lim = opt_t_q.fast_xfer ? XFER_FAST_CYC : XFER_SLOW_CYC;
      latch3_n = ms_to_samples(LATCH3_MS, fast);
      latch30_n = ms_to_samples(LATCH30_MS, fast);
      min_pulse_n = ms_to_samples(MIN_PULSE_MS, fast);
      freeze_n = (opt_b_q.freeze == FRZ_45S) ? ms_to_samples(FREEZE45_MS, fast)
                                             : ms_to_samples(FREEZE15_MS, fast);
      margin = margin_of(opt_b_q.margin);
   end

   // ==========================================
   // Sample interval and transfer rate dividers
   logic [BW-1:0] base_cnt_q;
   logic phase_q;
   logic sample_tick_q;
   logic [7:0] xfer_cnt_q;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         base_cnt_q <= '0;
         phase_q <= 1'b0;
         sample_tick_q <= 1'b0;
      end else begin
         sample_tick_q <= 1'b0;
         if (base_cnt_q == BW'(BASE_CYC - 1)) begin
            base_cnt_q <= '0;
            phase_q <= ~phase_q;
            sample_tick_q <= cap_done_q & (fast | phase_q);
         end else begin
            base_cnt_q <= base_cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         xfer_cnt_q <= 8'h00;
         transfer_tick <= 1'b0;
      end else begin
         transfer_tick <= 1'b0;
         if (xfer_cnt_q >= xfer_lim - 8'h01) begin
            xfer_cnt_q <= 8'h00;
            transfer_tick <= cap_done_q;
         end else begin
            xfer_cnt_q <= xfer_cnt_q + 8'h01;
         end
      end
   end

   // ==========================================
   // Detection filter
   logic [3:0] entry_n_q;
   logic [3:0] exit_n_q;
   logic [3:0] ent_cnt_q;
   logic [3:0] ext_cnt_q;
   logic detect_q;
   logic [15:0] ref_q;
   logic ref_init_q;
   logic [12:0] frz_cnt_q;
   logic expired;
   logic below;

   always_comb begin
      below = ref_init_q && ({1'b0, meas.count} + {1'b0, margin} < {1'b0, ref_q});
      expired = (opt_b_q.freeze != FRZ_INFINITE) && (frz_cnt_q >= freeze_n);
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ent_cnt_q <= 4'h0;
         ext_cnt_q <= 4'h0;
         detect_q <= 1'b0;
      end else if (meas.valid && cap_done_q) begin
         if (!detect_q) begin
            ext_cnt_q <= 4'h0;
            if (!below) begin
               ent_cnt_q <= 4'h0;
            end else if (ent_cnt_q + 4'h1 >= entry_n_q) begin
               ent_cnt_q <= 4'h0;
               detect_q <= 1'b1;
            end else begin
               ent_cnt_q <= ent_cnt_q + 4'h1;
            end
         end else begin
            ent_cnt_q <= 4'h0;
            if (below) begin
               ext_cnt_q <= 4'h0;
            end else if (ext_cnt_q + 4'h1 >= exit_n_q) begin
               ext_cnt_q <= 4'h0;
               detect_q <= 1'b0;
            end else begin
               ext_cnt_q <= ext_cnt_q + 4'h1;
            end
         end
      end
   end

   // Reference held while detecting, until the freeze limit runs out
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ref_q <= 16'h0000;
         ref_init_q <= 1'b0;
      end else if (meas.valid && cap_done_q) begin
         if (!ref_init_q) begin
            ref_q <= meas.count;
            ref_init_q <= 1'b1;
         end else if (!detect_q || expired) begin
            if (meas.count > ref_q) begin
               ref_q <= ref_q + 16'h0001;
            end else if (meas.count < ref_q) begin
               ref_q <= ref_q - 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         frz_cnt_q <= 13'h0000;
      end else if (!detect_q) begin
         frz_cnt_q <= 13'h0000;
      end else if (sample_tick_q && !expired) begin
         frz_cnt_q <= frz_cnt_q + 13'h0001;
      end
   end

   // ==========================================
   // Acquisition scheduling by power mode
   logic [4:0] skip_cnt_q;
   logic awake;

   assign awake = detect_q | (ent_cnt_q != 4'h0);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         skip_cnt_q <= 5'h00;
         acq_request <= 1'b0;
      end else begin
         acq_request <= 1'b0;
         if (sample_tick_q) begin
            if (skip_cnt_q + 5'h01 >= acq_interval(opt_b_q.power, awake)) begin
               skip_cnt_q <= 5'h00;
               acq_request <= 1'b1;
            end else begin
               skip_cnt_q <= skip_cnt_q + 5'h01;
            end
         end
      end
   end

   // ==========================================
   // Output behaviour
   logic det_prev_q;
   logic rise;
   logic toggle_q;
   logic [12:0] hold_q;
   logic [12:0] min_q;
   logic want;

   assign rise = detect_q & ~det_prev_q;

   always_comb begin
      case (opt_b_q.outmode)
         OM_FOLLOW: want = detect_q;
         OM_TOGGLE: want = toggle_q;
         OM_LATCH3: want = detect_q | (hold_q != 13'h0000);
         OM_LATCH30: want = detect_q | (hold_q != 13'h0000);
         default: want = detect_q;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         det_prev_q <= 1'b0;
         toggle_q <= 1'b0;
      end else begin
         det_prev_q <= detect_q;
         if (rise) begin
            toggle_q <= ~toggle_q;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hold_q <= 13'h0000;
      end else if (opt_b_q.outmode == OM_LATCH3 && rise) begin
         hold_q <= latch3_n;
      end else if (opt_b_q.outmode == OM_LATCH30 && detect_q) begin
         hold_q <= latch30_n;
      end else if (sample_tick_q && hold_q != 13'h0000) begin
         hold_q <= hold_q - 13'h0001;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         detect_output_pin <= 1'b0;
         min_q <= 13'h0000;
      end else if (want && !detect_output_pin) begin
         detect_output_pin <= 1'b1;
         min_q <= min_pulse_n;
      end else if (!want && detect_output_pin && min_q == 13'h0000) begin
         detect_output_pin <= 1'b0;
      end else if (sample_tick_q && min_q != 13'h0000) begin
         min_q <= min_q - 13'h0001;
      end
   end

   // ==========================================
   // Register port
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         entry_n_q <= ENTRY_DEB_RST;
         exit_n_q <= EXIT_DEB_RST;
      end else if (reg_wr && reg_addr == ADDR_DEBOUNCE) begin
         entry_n_q <= reg_wdata[DEB_ENTRY_LSB +: 4];
         exit_n_q <= reg_wdata[DEB_EXIT_LSB +: 4];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (!reg_rd) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_addr == ADDR_TIMING) begin
         reg_rdata <= {24'h000000, opt_t_q};
      end else if (reg_addr == ADDR_BEHAV) begin
         reg_rdata <= {24'h000000, opt_b_q};
      end else if (reg_addr == ADDR_DEBOUNCE) begin
         reg_rdata <= {24'h000000, exit_n_q, entry_n_q};
      end else if (reg_addr == ADDR_STATUS) begin
         reg_rdata <= {26'h0000000, cap_done_q, awake, expired, detect_q & ~expired,
                       detect_q, detect_output_pin};
      end else if (reg_addr == ADDR_REFERENCE) begin
         reg_rdata <= {16'h0000, ref_q};
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule : tod_sensor_out

// ### tb/tod_load_model.sv
// Load model: counts switch-on events of the driven output
`timescale 1ns/1ps

module tod_load_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic drive,
   output logic [15:0] rises
);
   logic last_q;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         last_q <= 1'b0;
         rises <= '0;
      end else begin
         last_q <= drive;
         rises <= rises + 16'(drive & ~last_q);
      end
   end
endmodule : tod_load_model

// ### tb/tod_sensor_out_bench.sv
// Testbench: self-checking run of the detection output block
`timescale 1ns/1ps

module tod_sensor_out_bench;
   import tod_pkg::*;
   localparam int BASE = 10;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] tbyte = 8'h00;
   logic [7:0] bbyte = 8'h00;
   tod_meas_t meas = '0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata, obs, mg, mw, n;
   logic pin, xtick, acq;
   logic probe = 1'b0;
   logic rd_seen = 1'b0;
   logic [15:0] rises, base;
   logic [31:0] exp_q[$];
   int num_errors = 0;
   int checks_done = 0;
   int i;

   always #20 mclk = ~mclk;

   tod_sensor_out #(.BASE_CYC(BASE)) uut (.mclk(mclk), .rst_n(rst_n),
      .timing_option_byte(tbyte), .behaviour_option_byte(bbyte), .meas(meas),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .detect_output_pin(pin), .transfer_tick(xtick),
      .acq_request(acq));
   tod_load_model load (.mclk(mclk), .rst_n(rst_n), .drive(pin), .rises(rises));

   // ==========================================
   // Result monitor
   always @(posedge mclk) begin
      rd_seen <= reg_rd;
      if (rd_seen || probe) begin
         mg = rd_seen ? reg_rdata : obs;
         mw = exp_q.pop_front();
         checks_done++;
         if (mg !== mw) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, mg, mw);
         end
      end
   end

   // ==========================================
   // Drivers
   task automatic note(input logic [31:0] e, input logic [31:0] v);
      exp_q.push_back(e);
      obs <= v;
      probe <= 1'b1;
      @(posedge mclk);
      probe <= 1'b0;
      @(posedge mclk);
   endtask : note
   task automatic pin_is(input logic e);
      repeat (2) @(posedge mclk);
      note({31'h0, e}, {31'h0, pin});
   endtask : pin_is
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask : wr
   task automatic samp(input logic [15:0] c, input int k);
      repeat (k) begin
         meas <= '{valid: 1'b1, count: c};
         @(posedge mclk);
         meas.valid <= 1'b0;
         repeat ($urandom_range(4, 1)) @(posedge mclk);
      end
   endtask : samp
   task automatic boot(input logic [7:0] t, input logic [7:0] b);
      rst_n <= 1'b0;
      tbyte <= t;
      bbyte <= b;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (8) @(posedge mclk);
   endtask : boot
   // Cycles between two pulses, sampled mid-cycle
   task automatic gap(input logic sel, output logic [31:0] g);
      int k;
      g = 32'h0;
      for (k = 0; k < 4000 && (sel ? acq : xtick) !== 1'b1; k++) @(negedge mclk);
      do begin
         @(negedge mclk);
         g = g + 32'h1;
      end while ((sel ? acq : xtick) !== 1'b1 && g < 32'hFA0);
      @(posedge mclk);
   endtask : gap
   task automatic close_out();
      if (num_errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (90000) @(posedge mclk);
      num_errors++;
      close_out();
   end

   // ==========================================
   // Scenarios
   initial begin
      void'($urandom(32'hEC53A44D));
      base = 16'h1000 + 16'($urandom_range(255, 0));
      boot(8'h00, 8'h00);
      rd(ADDR_TIMING, 32'h0);
      rd(ADDR_BEHAV, 32'h0);
      rd(ADDR_DEBOUNCE, 32'h33);
      wr(ADDR_TIMING, 32'hFF);
      rd(ADDR_TIMING, 32'h0);
      rd(8'h14, 32'h0);
      pin_is(1'b0);
      for (i = 0; i < 8; i++) begin
         boot({5'h0, i[2], i[0], 1'b0}, {i[1:0], 6'h00});
         gap(1'b0, n);
         note(i[0] ? 32'h64 : 32'hC8, n);
         gap(1'b1, n);
         note((i[1:0] == 2'h1 ? 1 : (i[1:0] == 2'h0 ? 5 : 17)) *
              (i[2] ? BASE : 2 * BASE), n);
      end
      for (i = 0; i < 4; i++) begin
         boot(8'h04, {2'b01, 2'(i), 4'h0});
         wr(ADDR_DEBOUNCE, 32'h11);
         rd(ADDR_DEBOUNCE, 32'h11);
         samp(base, 4);
         samp(base - 16'hC, 30);
         pin_is(!i[0]);
         samp(base, 2);
         pin_is(1'b0);
      end
      // Zoom mode wakes to every tick while detecting; reference frozen
      boot(8'h04, 8'h00);
      samp(base, 4);
      samp(base - 16'h40, 3);
      gap(1'b1, n);
      note(BASE, n);
      rd(ADDR_STATUS, 32'h37);
      rd(ADDR_REFERENCE, {16'h0, base - 16'h3});
      boot(8'h04, 8'h41);
      samp(base, 4);
      samp(base - 16'h40, 2);
      pin_is(1'b0);
      samp(base - 16'h40, 1);
      pin_is(1'b1);
      samp(base, 40);
      pin_is(1'b1);
      samp(base - 16'h40, 3);
      pin_is(1'b0);
      note(32'h1, {16'h0, rises});
      boot(8'h04, 8'h42);
      samp(base, 4);
      samp(base - 16'h40, 3);
      samp(base, 4);
      repeat (2850) @(posedge mclk);
      pin_is(1'b1);
      repeat (250) @(posedge mclk);
      pin_is(1'b0);
      boot(8'h04, 8'h43);
      samp(base, 4);
      for (i = 0; i < 2; i++) begin
         samp(base - 16'h40, 3);
         samp(base, 4);
         repeat (i ? 29000 : 20000) @(posedge mclk);
      end
      pin_is(1'b1);
      repeat (1500) @(posedge mclk);
      pin_is(1'b0);
      close_out();
   end
endmodule : tod_sensor_out_bench

// ### tb/tod_sensor_out_props.sv
// Checker: port properties of the detection output block
`timescale 1ns/1ps

module tod_sensor_out_props #(
   parameter int BASE_CYC = tod_pkg::BASE_CYC
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] timing_option_byte,
   input wire logic [7:0] behaviour_option_byte,
   input wire tod_pkg::tod_meas_t meas,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic detect_output_pin,
   input wire logic transfer_tick,
   input wire logic acq_request
);
   import tod_pkg::*;
   logic [31:0] high_q;
   logic [8:0] gap_q;
   logic seen_q;
   logic [8:0] per;
   logic [1:0] mode;
   assign per = timing_option_byte[1] ? 9'(XFER_FAST_CYC) : 9'(XFER_SLOW_CYC);
   assign mode = behaviour_option_byte[1:0];

   // ==========================================
   // Helper counters
   always_ff @(posedge mclk) begin
      if (!rst_n || !detect_output_pin) begin
         high_q <= '0;
      end else begin
         high_q <= high_q + 32'h1;
      end
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         gap_q <= '0;
         seen_q <= 1'b0;
      end else begin
         gap_q <= transfer_tick ? 9'h1 : gap_q + 9'h1;
         seen_q <= seen_q | transfer_tick;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // ==========================================
   // Assertions
   a_reset_idle: assert property ($rose(rst_n) |-> !detect_output_pin && !acq_request)
      else $error("output active after reset");
   a_tick_period: assert property (transfer_tick && seen_q |-> gap_q == per)
      else $error("transfer tick period wrong");
   a_min_pulse: assert property ($fell(detect_output_pin) |-> high_q >= 32'(4 * BASE_CYC))
      else $error("pin pulse too short");
   // Toggle adds one stage between the detect flag and the pin
   a_rise_sampled: assert property ($rose(detect_output_pin) |->
      $past(meas.valid) || $past(meas.valid, 2) || (mode == OM_TOGGLE && $past(meas.valid, 3)))
      else $error("pin rose without a sample");
   a_latch_short: assert property ($fell(detect_output_pin) && mode == OM_LATCH3 |->
      high_q >= 32'(298 * BASE_CYC))
      else $error("short latch fell early");
   a_latch_long: assert property ($fell(detect_output_pin) && mode == OM_LATCH30 |->
      high_q >= 32'(2998 * BASE_CYC))
      else $error("long latch fell early");
   a_acq_spaced: assert property (acq_request |=> !acq_request [*8])
      else $error("acquisitions too close");
   a_timing_read: assert property (reg_rd && reg_addr == ADDR_TIMING |=>
      reg_rdata == {24'h0, timing_option_byte})
      else $error("timing byte read wrong");
   a_behav_read: assert property (reg_rd && reg_addr == ADDR_BEHAV |=>
      reg_rdata == {24'h0, behaviour_option_byte})
      else $error("behaviour byte read wrong");
   c_toggle_rise: cover property ($rose(detect_output_pin) && mode == OM_TOGGLE);
   c_long_fall: cover property ($fell(detect_output_pin) && mode == OM_LATCH30);
   c_read_data: cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule : tod_sensor_out_props

bind tod_sensor_out tod_sensor_out_props #(.BASE_CYC(BASE_CYC)) u_props (
   .mclk(mclk), .rst_n(rst_n), .timing_option_byte(timing_option_byte),
   .behaviour_option_byte(behaviour_option_byte), .meas(meas), .reg_addr(reg_addr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .detect_output_pin(detect_output_pin),
   .transfer_tick(transfer_tick), .acq_request(acq_request)
);
